// ### rtl/and_unit_map.svh
/*
 Constants for the accumulator logical-AND unit: widths, limits, bit
 positions and reset values. Assumes it is included by the package and
 by the unit itself; the include guard makes repeat inclusion harmless.
*/
// What this block does
// - word AND on accumulator low sixteen bits
// - word AND sets zero flag from result
// - double AND with two words or constant
// - 32-bit AND variants set zero flag
// - 32-bit AND variants copy bit 31 negative
// - AND with run of 1-32 discrete bits
// - run uses start address and bit count
// - stack AND with first stack level
// - stack AND pops, remaining levels move up
// - flags hold until an affecting operation
// - every stack level holds 32 bits
`ifndef AND_UNIT_MAP_SVH
`define AND_UNIT_MAP_SVH

`define AU_WORD_W 16
`define AU_ACC_W 32
`define AU_ADDR_W 16
`define AU_COUNT_W 6
`define AU_SIGN_BIT 31
`define AU_STACK_DEPTH 8
`define AU_RUN_MIN 6'h01
`define AU_RUN_MAX 6'h20
`define AU_ACC_RESET 32'h00000000
`define AU_FLAG_RESET 1'b0
`define AU_HIGH_ZERO 16'h0000

`endif

// ### rtl/and_unit_pkg.sv
/*
 Types shared by the accumulator logical-AND unit and its bench: the
 operation codes, the command bundle and the sequencer states.
 Assumes and_unit_map.svh is on the include path.
*/
package and_unit_pkg;
    `include "and_unit_map.svh"

    typedef enum logic [2:0]
    {
        OP_AND_WORD,
        OP_AND_DOUBLE,
        OP_AND_RANGE,
        OP_AND_STACK,
        OP_LOAD_PUSH
    } op_t;

    typedef struct packed
    {
        op_t op;
        logic useConst;
        logic [`AU_ADDR_W-1:0] addr;
        logic [`AU_COUNT_W-1:0] bitCount;
        logic [`AU_ACC_W-1:0] konst;
    } cmd_t;

    typedef enum logic [1:0]
    {
        ST_IDLE,
        ST_REQ,
        ST_DATA
    } state_t;
endpackage

// ### rtl/accumulator_logical_and_unit.sv
/*
 Accumulator logical-AND execution unit: the accumulator, its stack and
 the zero/negative result flags, with read ports toward the word memory
 and the discrete bit memory. Assumes both memories are synchronous to
 clk and return read data in the cycle after the one their enable is high.
*/
`include "and_unit_map.svh"

module accumulator_logical_and_unit
    import and_unit_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // command
    input wire logic cmdValid,
    input wire cmd_t cmd,
    output logic cmdReady,
    output logic opDone,
    // word memory read port
    output logic memRdEn,
    output logic [`AU_ADDR_W-1:0] memAddr,
    input wire logic [`AU_WORD_W-1:0] memRdLo,
    input wire logic [`AU_WORD_W-1:0] memRdHi,
    // discrete bit memory read port
    output logic discRdEn,
    output logic [`AU_ADDR_W-1:0] discAddr,
    input wire logic [`AU_ACC_W-1:0] discRdBits,
    // state
    output logic [`AU_ACC_W-1:0] accValue,
    output logic [`AU_ACC_W-1:0] stackTop,
    output logic zeroResultFlag,
    output logic negativeResultFlag
);

    // mask of the lowest n bits, n held inside 1..32
    function automatic logic [`AU_ACC_W-1:0] runMask(input logic [`AU_COUNT_W-1:0] n);
        logic [`AU_COUNT_W-1:0] nn;
        nn = (n < `AU_RUN_MIN) ? `AU_RUN_MIN : ((n > `AU_RUN_MAX) ? `AU_RUN_MAX : n);
        return 32'hFFFFFFFF >> (`AU_RUN_MAX - nn);
    endfunction

    state_t state_q;
    state_t state_d;
    cmd_t cur_q;
    logic cmdReady_q;
    logic opDone_q;
    logic memRdEn_q;
    logic discRdEn_q;
    logic [`AU_ADDR_W-1:0] memAddr_q;
    logic [`AU_ADDR_W-1:0] discAddr_q;
    logic [`AU_ACC_W-1:0] acc_q;
    logic [`AU_ACC_W-1:0] acc_d;
    logic [`AU_ACC_W-1:0] stack_q [`AU_STACK_DEPTH];
    logic zero_q;
    logic zero_d;
    logic neg_q;
    logic neg_d;
    op_t lastOp_q;

    // decode of the operation being executed this cycle
    wire logic accept = (state_q == ST_IDLE) && cmdValid && cmdReady_q;
    wire logic needsMem = (cmd.op == OP_AND_WORD) || (cmd.op == OP_AND_RANGE)
        || ((cmd.op == OP_AND_DOUBLE) && !cmd.useConst);
    wire logic execNow = (accept && !needsMem) || (state_q == ST_DATA);
    wire cmd_t opCmd = (state_q == ST_DATA) ? cur_q : cmd;
    wire logic isAnd = (opCmd.op != OP_LOAD_PUSH);
    wire logic isWide = isAnd && (opCmd.op != OP_AND_WORD);
    wire logic isPop = (opCmd.op == OP_AND_STACK);
    wire logic isPush = (opCmd.op == OP_LOAD_PUSH);

    // operand selection; the word form uses only the low half
    wire logic [`AU_ACC_W-1:0] wordOperand = {`AU_HIGH_ZERO, memRdLo};
    wire logic [`AU_ACC_W-1:0] doubleOperand = opCmd.useConst ? opCmd.konst : {memRdHi, memRdLo};
    wire logic [`AU_ACC_W-1:0] rangeOperand = discRdBits & runMask(opCmd.bitCount);
    wire logic [`AU_ACC_W-1:0] stackOperand = stack_q[0];
    wire logic [`AU_ACC_W-1:0] operand =
        (opCmd.op == OP_AND_WORD) ? wordOperand :
        (opCmd.op == OP_AND_DOUBLE) ? doubleOperand :
        (opCmd.op == OP_AND_RANGE) ? rangeOperand : stackOperand;
    wire logic [`AU_ACC_W-1:0] andResult = acc_q & operand;

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: state_d = (accept && needsMem) ? ST_REQ : ST_IDLE;
            ST_REQ: state_d = ST_DATA;
            ST_DATA: state_d = ST_IDLE;
        endcase
    end

    // result and flag next values; a flag an operation does not touch keeps its value
    always_comb
    begin
        acc_d = acc_q;
        zero_d = zero_q;
        neg_d = neg_q;
        if (execNow && isAnd)
        begin
            acc_d = andResult;
            zero_d = (andResult == `AU_ACC_RESET);
            if (isWide)
            begin
                neg_d = andResult[`AU_SIGN_BIT];
            end
        end
        else if (execNow)
        begin
            acc_d = opCmd.konst;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= ST_IDLE;
            cmdReady_q <= 1'b0;
            opDone_q <= 1'b0;
            memRdEn_q <= 1'b0;
            discRdEn_q <= 1'b0;
            memAddr_q <= `AU_HIGH_ZERO;
            discAddr_q <= `AU_HIGH_ZERO;
            cur_q <= '0;
            lastOp_q <= OP_AND_WORD;
        end
        else
        begin
            state_q <= state_d;
            cmdReady_q <= (state_d == ST_IDLE);
            opDone_q <= execNow;
            memRdEn_q <= accept && needsMem && (cmd.op != OP_AND_RANGE);
            discRdEn_q <= accept && (cmd.op == OP_AND_RANGE);
            if (accept)
            begin
                cur_q <= cmd;
                memAddr_q <= cmd.addr;
                discAddr_q <= cmd.addr;
            end
            if (execNow)
            begin
                lastOp_q <= opCmd.op;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acc_q <= `AU_ACC_RESET;
            zero_q <= `AU_FLAG_RESET;
            neg_q <= `AU_FLAG_RESET;
        end
        else
        begin
            acc_q <= acc_d;
            zero_q <= zero_d;
            neg_q <= neg_d;
        end
    end

    // pop moves every level up and zero fills the bottom; push moves them down
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < `AU_STACK_DEPTH; i++)
            begin
                stack_q[i] <= `AU_ACC_RESET;
            end
        end
        else if (execNow && isPop)
        begin
            for (int i = 0; i < `AU_STACK_DEPTH - 1; i++)
            begin
                stack_q[i] <= stack_q[i+1];
            end
            stack_q[`AU_STACK_DEPTH-1] <= `AU_ACC_RESET;
        end
        else if (execNow && isPush)
        begin
            stack_q[0] <= acc_q;
            for (int i = 1; i < `AU_STACK_DEPTH; i++)
            begin
                stack_q[i] <= stack_q[i-1];
            end
        end
    end

    assign cmdReady = cmdReady_q;
    assign opDone = opDone_q;
    assign memRdEn = memRdEn_q;
    assign memAddr = memAddr_q;
    assign discRdEn = discRdEn_q;
    assign discAddr = discAddr_q;
    assign accValue = acc_q;
    assign stackTop = stack_q[0];
    assign zeroResultFlag = zero_q;
    assign negativeResultFlag = neg_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_word_and: assert property (state_q == ST_DATA && cur_q.op == OP_AND_WORD
        |=> acc_q == {`AU_HIGH_ZERO, $past(acc_q[15:0]) & $past(memRdLo)})
        else $error("word AND result wrong");
    a_word_zero: assert property (opDone_q && lastOp_q == OP_AND_WORD |-> zero_q == (acc_q == 32'h00000000))
        else $error("zero flag wrong after word AND");
    a_double_mem: assert property (accept && cmd.op == OP_AND_DOUBLE && !cmd.useConst
        ##2 1 |=> acc_q == ($past(acc_q) & {$past(memRdHi), $past(memRdLo)}))
        else $error("double AND from memory wrong");
    a_double_const: assert property (accept && cmd.op == OP_AND_DOUBLE && cmd.useConst
        |=> acc_q == ($past(acc_q) & $past(cmd.konst)) && opDone_q)
        else $error("double AND with constant wrong");
    a_wide_zero: assert property (opDone_q && lastOp_q inside {OP_AND_DOUBLE, OP_AND_RANGE, OP_AND_STACK}
        |-> zeroResultFlag == (accValue == 32'h00000000))
        else $error("zero flag wrong after 32-bit AND");
    a_wide_neg: assert property (opDone_q && lastOp_q inside {OP_AND_DOUBLE, OP_AND_RANGE, OP_AND_STACK}
        |-> negativeResultFlag == accValue[31])
        else $error("negative flag wrong after 32-bit AND");
    a_range_req: assert property (accept && cmd.op == OP_AND_RANGE
        |=> discRdEn && discAddr == $past(cmd.addr) ##1 !discRdEn ##1 opDone_q)
        else $error("bit run request wrong");
    a_range_ext: assert property (state_q == ST_DATA && cur_q.op == OP_AND_RANGE && cur_q.bitCount == 6'h04
        |=> acc_q[31:4] == 28'h0000000)
        else $error("bit run not zero extended");
    a_stack_pop: assert property (execNow && isPop
        |=> acc_q == ($past(acc_q) & $past(stack_q[0])) && stack_q[0] == $past(stack_q[1]))
        else $error("stack AND or pop wrong");
    a_flag_hold: assert property (!opDone_q || lastOp_q == OP_LOAD_PUSH
        |-> $stable(zeroResultFlag) && $stable(negativeResultFlag))
        else $error("flag changed without an affecting operation");
    a_word_neg_hold: assert property (opDone_q && lastOp_q == OP_AND_WORD |-> $stable(negativeResultFlag))
        else $error("word AND touched negative flag");

endmodule // accumulator_logical_and_unit

// ### testbench/word_disc_mem_model.sv
/*
 Behavioural word memory and discrete bit memory for the logical-AND unit.
 Assumes reads are one-cycle enable pulses with data due in the next cycle only.
*/
module word_disc_mem_model
(
    // clock
    input wire logic clk,
    // word memory port
    input wire logic memRdEn,
    input wire logic [15:0] memAddr,
    output logic [15:0] memRdLo,
    output logic [15:0] memRdHi,
    // discrete bit port
    input wire logic discRdEn,
    input wire logic [15:0] discAddr,
    output logic [31:0] discRdBits
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wordHit;
    logic discHit;
    logic [31:0] wordLast;
    logic [31:0] discLast;
    always_ff @(posedge clk)
    begin
        wordHit <= memRdEn;
        discHit <= discRdEn;
        if (memRdEn)
            wordLast <= {memAddr ^ 16'h5A5A, ~memAddr};
        if (discRdEn)
            discLast <= {discAddr, ~discAddr};
    end
    // stale data is inverted so a late sample cannot pass by luck
    assign {memRdHi, memRdLo} = wordHit ? wordLast : ~wordLast;
    assign discRdBits = discHit ? discLast : ~discLast;
endmodule // word_disc_mem_model

// ### testbench/tb_top.sv
/*
 Self-checking bench for the accumulator logical-AND unit.
 Assumes the memory model above answers every read one cycle later.
*/
module tb_top
    import and_unit_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, cmdValid, cmdReady, opDone, memRdEn, discRdEn, zeroResultFlag, negativeResultFlag;
    cmd_t cmd;
    logic [15:0] memAddr, discAddr, memRdLo, memRdHi;
    logic [31:0] discRdBits, accValue, stackTop, expAcc;
    logic expZero, expNeg;
    logic [31:0] stk[$];
    int errorCnt = 0;
    int comparisons = 0;
    int cycles = 0;

    accumulator_logical_and_unit dut_u (.clk(clk), .rst_n(rst_n), .cmdValid(cmdValid), .cmd(cmd),
        .cmdReady(cmdReady), .opDone(opDone), .memRdEn(memRdEn), .memAddr(memAddr), .memRdLo(memRdLo),
        .memRdHi(memRdHi), .discRdEn(discRdEn), .discAddr(discAddr), .discRdBits(discRdBits),
        .accValue(accValue), .stackTop(stackTop), .zeroResultFlag(zeroResultFlag),
        .negativeResultFlag(negativeResultFlag));
    word_disc_mem_model mem_u (.clk(clk), .memRdEn(memRdEn), .memAddr(memAddr), .memRdLo(memRdLo),
        .memRdHi(memRdHi), .discRdEn(discRdEn), .discAddr(discAddr), .discRdBits(discRdBits));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic wrap_up();
        if (errorCnt == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // a hang costs at most a few thousand cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            errorCnt++;
            wrap_up();
        end
    end

    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            errorCnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // updates the reference, issues one command and compares every result
    task automatic exec(op_t op, logic useC, logic [15:0] a, logic [5:0] cnt, logic [31:0] k);
        logic [31:0] mask;
        int n;
        mask = (cnt >= 6'h20) ? 32'hFFFFFFFF : (32'h1 << ((cnt == 6'h00) ? 6'h01 : cnt)) - 32'h1;
        case (op)
            OP_AND_WORD: expAcc = {16'h0000, expAcc[15:0] & ~a};
            OP_AND_DOUBLE: expAcc &= useC ? k : {a ^ 16'h5A5A, ~a};
            OP_AND_RANGE: expAcc &= {a, ~a} & mask;
            OP_AND_STACK: expAcc &= (stk.size() > 0) ? stk.pop_front() : 32'h00000000;
            default:
            begin
                stk.push_front(expAcc);
                if (stk.size() > 8)
                    void'(stk.pop_back());
                expAcc = k;
            end
        endcase
        if (op != OP_LOAD_PUSH)
            expZero = (expAcc == 32'h00000000);
        if (op != OP_LOAD_PUSH && op != OP_AND_WORD)
            expNeg = expAcc[31];
        // one edge always passes, so cmdValid never drops and rises in one time step
        @(negedge clk);
        n = 0;
        while (cmdReady !== 1'b1 && n < 10)
        begin
            @(negedge clk);
            n++;
        end
        cmd = '{op: op, useConst: useC, addr: a, bitCount: cnt, konst: k};
        cmdValid = 1'b1;
        @(negedge clk);
        cmdValid = 1'b0;
        n = 0;
        while (opDone !== 1'b1 && n < 6)
        begin
            @(negedge clk);
            n++;
        end
        check("opDone", 32'h1, {31'h0, opDone});
        check("accValue", expAcc, accValue);
        check("zeroResultFlag", {31'h0, expZero}, {31'h0, zeroResultFlag});
        check("negativeResultFlag", {31'h0, expNeg}, {31'h0, negativeResultFlag});
        check("stackTop", (stk.size() > 0) ? stk[0] : 32'h00000000, stackTop);
    endtask

    task automatic double_case();
        exec(OP_LOAD_PUSH, 1'b0, 16'h0000, 6'h00, 32'h87654321);
        exec(OP_AND_DOUBLE, 1'b1, 16'h0000, 6'h00, 32'hF000000F);
        exec(OP_AND_DOUBLE, 1'b0, 16'h0F0F, 6'h00, 32'h00000000);
        exec(OP_LOAD_PUSH, 1'b0, 16'h0000, 6'h00, 32'hFFFFFFFF);
        exec(OP_AND_DOUBLE, 1'b0, 16'h00FF, 6'h00, 32'h00000000);
        exec(OP_AND_DOUBLE, 1'b1, 16'h0000, 6'h00, 32'h80000000);
    endtask

    task automatic word_case();
        exec(OP_LOAD_PUSH, 1'b0, 16'h0000, 6'h00, 32'hFFFF1234);
        exec(OP_AND_WORD, 1'b0, 16'h0F00, 6'h00, 32'h00000000);
        exec(OP_AND_WORD, 1'b0, 16'hFFFF, 6'h00, 32'h00000000);
    endtask

    task automatic range_case();
        logic [5:0] counts[7] = '{6'h00, 6'h01, 6'h04, 6'h07, 6'h1F, 6'h20, 6'h28};
        foreach (counts[i])
        begin
            exec(OP_LOAD_PUSH, 1'b0, 16'h0000, 6'h00, 32'hFFFFFFFF);
            exec(OP_AND_RANGE, 1'b0, 16'hC3A5 + 16'(i), counts[i], 32'h00000000);
        end
    endtask

    task automatic stack_case();
        exec(OP_LOAD_PUSH, 1'b0, 16'h0000, 6'h00, 32'hA5F0C381);
        exec(OP_LOAD_PUSH, 1'b0, 16'h0000, 6'h00, 32'hFF00FF0F);
        exec(OP_LOAD_PUSH, 1'b0, 16'h0000, 6'h00, 32'hF0F0F0FF);
        exec(OP_AND_STACK, 1'b0, 16'h0000, 6'h00, 32'h00000000);
        exec(OP_AND_STACK, 1'b0, 16'h0000, 6'h00, 32'h00000000);
        repeat (3) exec(OP_AND_STACK, 1'b0, 16'h0000, 6'h00, 32'h00000000);
    endtask

    initial
    begin
        rst_n = 1'b0;
        cmdValid = 1'b0;
        cmd = '0;
        expAcc = 32'h00000000;
        expZero = 1'b0;
        expNeg = 1'b0;
        repeat (16) @(negedge clk);
        check("accValue", 32'h00000000, accValue);
        rst_n = 1'b1;
        @(negedge clk);
        double_case();
        word_case();
        range_case();
        stack_case();
        wrap_up();
    end
endmodule // tb_top
